// ===== hw/lpb_map.svh
`ifndef LPB_MAP_SVH
`define LPB_MAP_SVH
// Register byte offsets.
`define LPB_OFF_CMP 8'h00
`define LPB_OFF_CTL 8'h04
`define LPB_OFF_STAT 8'h08
`define LPB_OFF_BUF0 8'h20
// Field positions.
`define LPB_CTL_MODE 0
`define LPB_CTL_EN 2
`define LPB_STAT_BUSY 8
`define LPB_STAT_DMA 9
// Reset values: one beat, baud divider of four.
`define LPB_CMP_RST 16'h0101
`define LPB_CTL_RST 3'h0
`endif

// ===== hw/lpb_pkg.sv
package lpb_pkg;
	// Transfer modes, in the order of the control field.
	typedef enum logic [1:0] {LPB_SGL_WR, LPB_SGL_RD, LPB_MUL_WR, LPB_MUL_RD} lpb_mode_t;
	// Strobe timer states.
	typedef enum logic [1:0] {S_IDLE, S_RUN, S_STOP} lpb_tstate_t;
	// Compare value: edge count high, half period low.
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} lpb_cmp_t;
	// Control register.
	typedef struct packed {
		logic en;
		lpb_mode_t mode;
	} lpb_ctl_t;
	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} lpb_req_t;
endpackage

// ===== hw/lpb_engine.sv
`timescale 1ns/1ps
`include "lpb_map.svh"
// How it works
// R1: Last receive shifter captures pin byte directly.
// R2: Receive shifters sample on shift clock fall.
// R3: Transmit shifter updates pins on clock rise.
// R4: Read modes release data pins as inputs.
// R5: Each shifter fed by next shifter's output.
// R6: Only first shifter drives bus in writes.
// R7: Compare high byte counts twice beats minus one.
// R8: Compare low byte sets strobe half period.
// R9: Timer output high when enabled, is shift clock.
// R10: Timer starts on trigger, stops on compare.
// R11: Read modes add stop period on disable.
// R12: Write modes use no stop or start.
// R13: Single read, multi write trigger on last flag.
// R14: Multi read triggers on first flag.
// R15: Read modes drive active low read strobe.
// R16: Write modes drive active low write strobe.
// R17: Dual eight bit counter in baud mode.
// R18: Compare stores shifters, sets flags, requests DMA.
// R19: Reading buffers clears flags, rearms timer.
// R20: Software drives chip and register select.
// R21: Panel latches on strobe rise.
module lpb_engine import lpb_pkg::*; #(
	parameter int NSH = 8
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic arst_n,
	// Register port.
	input wire lpb_req_t bus_req,
	output logic [31:0] rdata,
	// Panel data pins.
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_n,
	// Panel strobes and DMA request.
	output logic wr_n,
	output logic rd_n,
	output logic dma_req
);
	logic [1:0] rst_q;
	logic rst_n;
	lpb_ctl_t ctl_q, ctl_d;
	lpb_cmp_t cmp_q, cmp_d;
	logic [31:0] rdata_q, rdata_d;
	lpb_tstate_t st_q, st_d;
	logic out_q, out_d;
	logic [7:0] lo_q, lo_d, hi_q, hi_d;
	logic go, cmp_ev, pos_ev, neg_ev, trig_flag, rd_mode;
	logic [1:0] rx_neg_q, rx_neg_d, rx_st_q, rx_st_d;
	logic rx_shift, rx_store, rx_pend;
	logic [31:0] sh_q [NSH];
	logic [31:0] sh_d [NSH];
	logic [31:0] buf_q [NSH];
	logic [31:0] buf_d [NSH];
	logic [NSH-1:0] flag_q, flag_d, mask;
	logic [7:0] din_m_q, din_s_q;
	logic oe_n_q, oe_n_d, wr_n_q, wr_n_d, rd_n_q, rd_n_d, dma_q, dma_d;

	function automatic logic is_rd(lpb_mode_t m);
		return (m == LPB_SGL_RD) || (m == LPB_MUL_RD);
	endfunction

	function automatic logic is_buf(logic [7:0] a);
		return (a >= `LPB_OFF_BUF0) && (int'(a) < int'(`LPB_OFF_BUF0) + 4 * NSH) && (a[1:0] == 2'h0);
	endfunction

	function automatic int buf_idx(logic [7:0] a);
		return int'(a - `LPB_OFF_BUF0) >> 2;
	endfunction

	// Shifters taking part in a transfer; single beats use one end of the chain.
	function automatic logic [NSH-1:0] use_mask(lpb_mode_t m);
		case (m)
			LPB_SGL_WR: return NSH'(1);
			LPB_SGL_RD: return NSH'(1) << (NSH - 1);
			default: return '1;
		endcase
	endfunction

	// Reset release is synchronised so every flop leaves reset on the same edge.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'h1};
		end
	end
	assign rst_n = rst_q[1];

	assign rd_mode = is_rd(ctl_q.mode);
	assign mask = use_mask(ctl_q.mode);
	// Active low trigger source picks the first or last status flag.
	always_comb begin
		if (ctl_q.mode == LPB_SGL_WR || ctl_q.mode == LPB_MUL_RD) begin
			trig_flag = flag_q[0]; // see R14
		end else begin
			trig_flag = flag_q[NSH-1]; // see R13
		end
	end

	// Register port: writes take effect at once, reads answer one cycle later.
	always_comb begin
		ctl_d = ctl_q;
		cmp_d = cmp_q;
		rdata_d = 32'h0;
		if (bus_req.we) begin
			if (bus_req.addr == `LPB_OFF_CMP) begin
				cmp_d = bus_req.wdata[15:0];
			end else if (bus_req.addr == `LPB_OFF_CTL) begin
				ctl_d.mode = lpb_mode_t'(bus_req.wdata[`LPB_CTL_MODE +: 2]);
				ctl_d.en = bus_req.wdata[`LPB_CTL_EN];
			end
		end
		if (bus_req.re) begin
			if (bus_req.addr == `LPB_OFF_CMP) begin
				rdata_d[15:0] = cmp_q;
			end else if (bus_req.addr == `LPB_OFF_CTL) begin
				rdata_d[`LPB_CTL_MODE +: 2] = ctl_q.mode;
				rdata_d[`LPB_CTL_EN] = ctl_q.en;
			end else if (bus_req.addr == `LPB_OFF_STAT) begin
				rdata_d[NSH-1:0] = flag_q;
				rdata_d[`LPB_STAT_BUSY] = (st_q != S_IDLE) || rx_pend;
				rdata_d[`LPB_STAT_DMA] = dma_q;
			end else if (is_buf(bus_req.addr)) begin
				rdata_d = buf_q[buf_idx(bus_req.addr)];
			end
		end
	end

	// Strobe timer: low counter paces half periods, high counter counts edges.
	always_comb begin
		st_d = st_q;
		out_d = out_q;
		lo_d = lo_q;
		hi_d = hi_q;
		go = 1'h0;
		cmp_ev = 1'h0;
		pos_ev = 1'h0;
		neg_ev = 1'h0;
		case (st_q)
			S_IDLE: begin
				if (ctl_q.en && !trig_flag && !rx_pend) begin // see R10, see R11
					go = 1'h1;
					st_d = S_RUN;
					out_d = 1'h1; // see R9
					lo_d = cmp_q.lo; // see R8
					hi_d = cmp_q.hi; // see R7
				end
			end
			S_RUN: begin
				if (lo_q == 8'h0) begin // see R17
					lo_d = cmp_q.lo;
					if (hi_q == 8'h0) begin
						cmp_ev = 1'h1; // see R10
						out_d = 1'h0;
						st_d = rd_mode ? S_STOP : S_IDLE; // see R11, see R12
					end else begin
						hi_d = hi_q - 8'h1;
						out_d = !out_q;
						pos_ev = !out_q; // see R9
						neg_ev = out_q;
					end
				end else begin
					lo_d = lo_q - 8'h1;
				end
			end
			default: begin
				// The stop period holds off a retrigger while the flags settle.
				if (lo_q == 8'h0) begin
					st_d = S_IDLE; // see R11
				end else begin
					lo_d = lo_q - 8'h1;
				end
			end
		endcase
	end

	// The pin synchroniser lags two cycles, so receive shifts and the store wait as long.
	// Without this the sample would be taken as the strobe rises, before the panel's data has passed the synchroniser.
	always_comb begin
		rx_neg_d = {rx_neg_q[0], neg_ev && rd_mode};
		rx_st_d = {rx_st_q[0], cmp_ev && rd_mode};
	end
	assign rx_shift = rx_neg_q[1];
	assign rx_store = rx_st_q[1];
	// A store still in flight holds off the next trigger until the flags are updated.
	assign rx_pend = (rx_st_q != 2'h0);

	// Shifter chain, buffers and status flags.
	always_comb begin
		sh_d = sh_q;
		buf_d = buf_q;
		flag_d = flag_q;
		// A mode change resets flags: transmit buffers start empty, receive ones unfilled.
		if (bus_req.we && bus_req.addr == `LPB_OFF_CTL) begin
			flag_d = is_rd(lpb_mode_t'(bus_req.wdata[`LPB_CTL_MODE +: 2])) ? '0 : '1;
		end
		if (bus_req.we && is_buf(bus_req.addr)) begin
			buf_d[buf_idx(bus_req.addr)] = bus_req.wdata;
			if (!rd_mode) begin
				flag_d[buf_idx(bus_req.addr)] = 1'h0;
			end
		end
		if (bus_req.re && is_buf(bus_req.addr) && rd_mode) begin
			flag_d[buf_idx(bus_req.addr)] = 1'h0; // see R19
		end
		for (int i = 0; i < NSH; i++) begin
			if (go && !rd_mode && mask[i]) begin
				sh_d[i] = buf_q[i];
				flag_d[i] = 1'h1;
			end
			if (pos_ev && !rd_mode) begin
				sh_d[i] = {(i == NSH - 1) ? 8'h0 : sh_q[(i + 1) % NSH][7:0], sh_q[i][31:8]}; // see R3, see R5, see R6
			end
			if (rx_shift) begin // see R2
				if (i == NSH - 1) begin
					sh_d[i] = {din_s_q, sh_q[i][31:8]}; // see R1, see R2
				end else begin
					sh_d[i] = {sh_q[i + 1][7:0], sh_q[i][31:8]}; // see R5
				end
			end
			// Set wins over a clear arriving in the same cycle.
			if (rx_store && mask[i]) begin
				buf_d[i] = sh_q[i]; // see R18
				flag_d[i] = 1'h1;
			end
		end
	end

	// Strobe drivers follow the timer's next output so strobes line up with shifts; bus enable and DMA use the current state.
	always_comb begin
		oe_n_d = rd_mode || !ctl_q.en; // see R4
		wr_n_d = !(out_d && !rd_mode); // see R16
		rd_n_d = !(out_d && rd_mode); // see R15
		dma_d = ctl_q.en && trig_flag; // see R18
	end

	// Panel data crosses in through two flops before the shifters see it.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			din_m_q <= 8'h0;
			din_s_q <= 8'h0;
		end else begin
			din_m_q <= data_i;
			din_s_q <= din_m_q;
		end
	end

	// State registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= `LPB_CTL_RST;
			cmp_q <= `LPB_CMP_RST;
			rdata_q <= 32'h0;
			st_q <= S_IDLE;
			out_q <= 1'h0;
			lo_q <= 8'h0;
			hi_q <= 8'h0;
			flag_q <= '0;
			oe_n_q <= 1'h1;
			wr_n_q <= 1'h1;
			rd_n_q <= 1'h1;
			dma_q <= 1'h0;
			rx_neg_q <= 2'h0;
			rx_st_q <= 2'h0;
			for (int i = 0; i < NSH; i++) begin
				sh_q[i] <= 32'h0;
				buf_q[i] <= 32'h0;
			end
		end else begin
			ctl_q <= ctl_d;
			cmp_q <= cmp_d;
			rdata_q <= rdata_d;
			st_q <= st_d;
			out_q <= out_d;
			lo_q <= lo_d;
			hi_q <= hi_d;
			flag_q <= flag_d;
			oe_n_q <= oe_n_d;
			wr_n_q <= wr_n_d;
			rd_n_q <= rd_n_d;
			dma_q <= dma_d;
			rx_neg_q <= rx_neg_d;
			rx_st_q <= rx_st_d;
			sh_q <= sh_d;
			buf_q <= buf_d;
		end
	end

	assign rdata = rdata_q;
	assign data_o = sh_q[0][7:0];
	assign data_oe_n = oe_n_q;
	assign wr_n = wr_n_q;
	assign rd_n = rd_n_q;
	assign dma_req = dma_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_strobe_excl: assert property (!(!wr_n_q && !rd_n_q)) // see R15
		else $error("both strobes low");
	a_wr_quiet_rd: assert property (rd_mode && $stable(ctl_q) |=> wr_n_q) // see R16
		else $error("write strobe active in read mode");
	a_start_high: assert property (st_q == S_IDLE && go |=> out_q && st_q == S_RUN && hi_q == cmp_q.hi) // see R10
		else $error("timer did not start on trigger");
	a_half_period: assert property (st_q == S_RUN && $past(st_q) == S_RUN && $changed(out_q) |-> $past(lo_q) == 8'h0) // see R8
		else $error("strobe toggled before half period");
	a_store_flags: assert property (rx_store |=> (flag_q & mask) == mask) // see R18
		else $error("store did not set flags");
	a_read_stop: assert property (cmp_ev && rd_mode |=> st_q == S_STOP ##1 st_q == S_STOP || cmp_q.lo == 8'h0) // see R11
		else $error("no stop period after read");
	a_write_nostop: assert property (cmp_ev && !rd_mode |=> st_q == S_IDLE) // see R12
		else $error("write mode kept timer busy");
	a_buf_clear: assert property (bus_req.re && is_buf(bus_req.addr) && rd_mode && !rx_store && !bus_req.we
		|=> !flag_q[buf_idx($past(bus_req.addr))]) // see R19
		else $error("buffer read left flag set");
	a_oe_read: assert property (st_q == S_RUN && rd_mode && $past(rd_mode) |-> data_oe_n) // see R4
		else $error("data pins driven in read mode");

	c_mul_wr: cover property (cmp_ev && ctl_q.mode == LPB_MUL_WR);
	c_mul_rd: cover property (cmp_ev && ctl_q.mode == LPB_MUL_RD);
	c_sgl_rd: cover property (cmp_ev && ctl_q.mode == LPB_SGL_RD);
	c_sgl_wr: cover property (cmp_ev && ctl_q.mode == LPB_SGL_WR);
endmodule // lpb_engine

// ===== test/lpb_panel.sv
`timescale 1ns/1ps
// Panel controller on the far side of the strobed bus.
module lpb_panel (
	// Software chip select, low around a transfer sequence.
	input wire logic cs_n,
	// Strobes and bus from the engine.
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [7:0] data_o,
	// Data back to the engine.
	output logic [7:0] data_i
);
	logic [7:0] cap [0:255];
	int wcnt = 0;
	int rcnt = 0;
	initial data_i = 8'h5a;
	// Write data is latched on the strobe rise.
	always @(posedge wr_n) begin
		if (!cs_n) begin
			cap[wcnt[7:0]] = data_o;
			wcnt = wcnt + 1;
		end
	end
	// Read data is driven while the strobe is low.
	always @(negedge rd_n) begin
		if (!cs_n) begin
			data_i = 8'h40 + rcnt[7:0];
		end
	end
	// Once released, the bus shows the inverse so stale data never looks valid.
	always @(posedge rd_n) begin
		data_i = ~data_i;
		if (!cs_n) begin
			rcnt = rcnt + 1;
		end
	end
endmodule // lpb_panel

// ===== test/test_lcd_parallel_bus_engine.sv
`timescale 1ns/1ps
module test_lcd_parallel_bus_engine import lpb_pkg::*;;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	lpb_req_t req = '0;
	logic [31:0] rdata;
	logic [7:0] data_i, data_o;
	logic data_oe_n, wr_n, rd_n, dma_req;
	logic cs_n = 1'b1;
	int err_total = 0;
	int samples_checked = 0;
	lpb_engine DUT (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(req), .rdata(rdata), .data_i(data_i),
		.data_o(data_o), .data_oe_n(data_oe_n), .wr_n(wr_n), .rd_n(rd_n), .dma_req(dma_req));
	lpb_panel p (.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_o(data_o), .data_i(data_i));
	// Clock at 200 MHz.
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk_sys);
		req.we <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe, so it is taken there.
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
		@(posedge clk_sys);
		req.re <= 1'b0;
		#1 v = rdata;
	endtask
	// The request of the previous mode lingers after a mode change, so it is let go first.
	task wait_dma();
		repeat (2) @(posedge clk_sys);
		for (int n = 0; n < 400 && dma_req !== 1'b1; n++) @(negedge clk_sys);
	endtask
	task t_reset_regs();
		logic [31:0] v;
		rd(8'h00, v);
		chk(v, 32'h0000_0101, "compare reset");
		rd(8'h04, v);
		chk(v, 32'h0, "control reset");
		rd(8'h44, v);
		chk(v, 32'h0, "unmapped read");
	endtask
	task t_single_write();
		int w0;
		w0 = p.wcnt;
		wr(8'h04, 32'h4);
		wr(8'h20, 32'h0000_00a5);
		for (int n = 0; n < 40 && p.wcnt == w0; n++) @(posedge clk_sys);
		chk(p.cap[w0[7:0]], 32'h0000_00a5, "single write byte");
		chk(data_oe_n, 32'h0, "bus driven in write");
		chk(rd_n, 32'h1, "read strobe idle in write");
	endtask
	task t_multi_write();
		int w0;
		wr(8'h00, 32'h0000_3f01);
		wr(8'h04, 32'h6);
		w0 = p.wcnt;
		for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), {8'h13, 8'h12, 8'h11, 8'h10} + {4{8'(4 * i)}});
		for (int n = 0; n < 400 && p.wcnt < w0 + 32; n++) @(posedge clk_sys);
		chk(32'(p.wcnt - w0), 32'd32, "write beats");
		for (int k = 0; k < 32; k++) chk(p.cap[8'(w0 + k)], 32'h10 + 32'(k), "chained byte");
		repeat (10) @(posedge clk_sys);
		chk(dma_req, 32'h1, "refill request");
	endtask
	task t_single_read();
		int r0;
		logic [31:0] v;
		wr(8'h00, 32'h0000_0101);
		r0 = p.rcnt;
		wr(8'h04, 32'h5);
		wait_dma();
		chk(dma_req, 32'h1, "single read store");
		chk(data_oe_n, 32'h1, "pins are inputs");
		chk(wr_n, 32'h1, "write strobe idle in read");
		rd(8'h3c, v);
		chk(v[31:24], 8'h40 + 8'(r0), "single read byte");
		repeat (20) @(posedge clk_sys);
	endtask
	task t_multi_read();
		int r0;
		logic [31:0] v;
		logic [7:0] b;
		wr(8'h00, 32'h0000_3f01);
		r0 = p.rcnt;
		wr(8'h04, 32'h7);
		wait_dma();
		chk(dma_req, 32'h1, "burst store");
		chk(32'(p.rcnt - r0), 32'd32, "read strobes");
		rd(8'h08, v);
		chk(v[7:0], 8'hff, "all flags set");
		for (int i = 7; i >= 0; i--) begin
			b = 8'h40 + 8'(r0 + 4 * i);
			rd(8'h20 + 8'(4 * i), v);
			chk(v, {b + 8'h3, b + 8'h2, b + 8'h1, b}, "burst word");
		end
		rd(8'h08, v);
		chk(v[9], 32'h0, "flags cleared, no request");
		chk(v[7:0], 32'h0, "all flags cleared");
	endtask
	task wrap_up();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Watchdog: the whole sequence needs a few hundred cycles.
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset_regs();
		cs_n <= 1'b0;
		t_single_write();
		t_multi_write();
		t_single_read();
		t_multi_read();
		cs_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		wrap_up();
	end
endmodule // test_lcd_parallel_bus_engine
